/* include/lane_cfg_pkg.sv */
// constants for the lane configuration register bank
// assumes one 20 MHz clock and a byte-wide register port from the serial slave
// What this block does
// - sense mode 00 keeps the lane input high impedance for good.
// - sense mode 01 probes every 12 ms, gives up after 50 tries.
// - sense mode 10 probes every 12 ms until a receiver is found.
// - auto modes stay high impedance until found, then apply 50 ohm.
// - register sense field governs only while detect override is set.
// - each lane has an 8-bit boost level, reset value 0x2f.
// - 3-bit swing code maps 0.6 V to 1.3 V; register resets 0xad.
// - swing register bit 6 selects the link protocol mode.
// - register protocol bit applies only while mode override is set.
// - swing register bit 7 enables output short-circuit protection.
// - detect override bit picks register over external sense control.
// - mode override bit picks register bit over the mode pin.
// - lane writes need register enable set or a correct checksum.
package lane_cfg_pkg;
    localparam logic [7:0] ADDR_DET0 = 8'h0e;
    localparam logic [7:0] ADDR_BOOST0 = 8'h0f;
    localparam logic [7:0] ADDR_RSV10 = 8'h10;
    localparam logic [7:0] ADDR_RSV11 = 8'h11;
    localparam logic [7:0] ADDR_RSV12 = 8'h12;
    localparam logic [7:0] ADDR_DET1 = 8'h15;
    localparam logic [7:0] ADDR_BOOST1 = 8'h16;
    localparam logic [7:0] ADDR_SWING1 = 8'h17;

    localparam logic [7:0] RST_DET = 8'h00;
    localparam logic [7:0] RST_BOOST = 8'h2f;
    localparam logic [7:0] RST_RSV10 = 8'had;
    localparam logic [7:0] RST_RSV11 = 8'h02;
    localparam logic [7:0] RST_RSV12 = 8'h00;
    localparam logic [7:0] RST_SWING = 8'had;

    localparam int SENSE_LSB = 2;
    localparam int SWING_LSB = 0;
    localparam int PROTO_BIT = 6;
    localparam int SHORT_BIT = 7;

    localparam logic [1:0] SENSE_HIZ = 2'h0;
    localparam logic [1:0] SENSE_AUTO_LIM = 2'h1;
    localparam logic [1:0] SENSE_AUTO_ANY = 2'h2;
    localparam logic [1:0] SENSE_TERM = 2'h3;

    localparam int CLK_HZ = 20000000;
    localparam int PROBE_MS = 12;
    localparam int PROBE_CYC = PROBE_MS * (CLK_HZ / 1000);
    localparam int DIV_W = 18;
    localparam logic [5:0] PROBE_LIMIT = 6'h32;
endpackage : lane_cfg_pkg

/* rtl/far_end_sense.sv */
// one lane's far-end receiver detection sequencer
// assumes tick_i is a one-cycle pulse each probe period, found_i synchronised
`timescale 1ns/100ps
module far_end_sense (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic [1:0] mode_i,
    input wire logic found_i,
    output logic probe_o,
    output logic term_o,
    output logic detected_o
);
    typedef enum logic [2:0] {HIZ, PROBING, FOUND, GAVE_UP, TERM} sense_t;
    typedef struct packed {
        sense_t st;
        logic [5:0] tries;
        logic probe;
        logic term;
    } sense_st_t;

    sense_st_t s;
    sense_st_t n;

    always_comb begin
        n = s;
        n.probe = 1'b0;
        if (restart_i) begin
            n.tries = '0;
            unique case (mode_i)
                lane_cfg_pkg::SENSE_HIZ: n.st = HIZ;
                lane_cfg_pkg::SENSE_TERM: n.st = TERM;
                default: n.st = PROBING;
            endcase
        end else begin
            unique case (s.st)
                PROBING: begin
                    if (found_i) begin
                        n.st = FOUND;
                    end else if (tick_i) begin
                        // give up one period after the last try
                        if (mode_i == lane_cfg_pkg::SENSE_AUTO_LIM &&
                            s.tries == lane_cfg_pkg::PROBE_LIMIT) begin
                            n.st = GAVE_UP;
                        end else begin
                            // unlimited when limit not in force
                            n.probe = 1'b1;
                            if (s.tries != lane_cfg_pkg::PROBE_LIMIT) begin
                                n.tries = s.tries + 6'h01;
                            end
                        end
                    end
                end
                HIZ, FOUND, GAVE_UP, TERM: n.st = s.st;
                default: n.st = HIZ;
            endcase
        end
        n.term = (n.st == FOUND) || (n.st == TERM);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign probe_o = s.probe;
    assign term_o = s.term;
    assign detected_o = (s.st == FOUND);

    probe_only_tick_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        probe_o |-> $past(tick_i)) else $error("probe without tick");
    // limited mode must stop probing once the try count is used up
    limit_tries_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (mode_i == lane_cfg_pkg::SENSE_AUTO_LIM && !restart_i &&
        s.tries == lane_cfg_pkg::PROBE_LIMIT) |=> !probe_o)
        else $error("probe after fifty tries");
    hiz_mode_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (restart_i && mode_i == lane_cfg_pkg::SENSE_HIZ) |=> !term_o)
        else $error("terminated in hiz mode");
    term_mode_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (restart_i && mode_i == lane_cfg_pkg::SENSE_TERM) |=>
        term_o && !probe_o) else $error("no termination in mode 11");
    found_term_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s.st == PROBING && found_i && !restart_i) |=> term_o && detected_o)
        else $error("found receiver not terminated");
endmodule : far_end_sense

/* rtl/lane_config_register_bank.sv */
// lane configuration register bank with per-lane detection sequencers
// assumes a byte register port from the serial slave on the same clock;
// override, enable and checksum verdict come from registers outside
`timescale 1ns/100ps
module lane_config_register_bank #(
    parameter int unsigned PROBE_CYC = lane_cfg_pkg::PROBE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic reg_enable_i,
    input wire logic checksum_ok_i,
    input wire logic detect_override_i,
    input wire logic mode_override_i,
    input wire logic [3:0] ext_sense_mode_i,
    input wire logic mode_pin_i,
    input wire logic [1:0] receiver_found_i,
    output logic [1:0] probe_o,
    output logic [1:0] term_50ohm_o,
    output logic [1:0] detected_o,
    output logic [15:0] input_boost_level_o,
    output logic [2:0] output_swing_o,
    output logic protocol_mode_o,
    output logic short_protect_o
);
    typedef struct packed {
        logic [3:0] sense_s1;
        logic [3:0] sense_s2;
        logic mode_s1;
        logic mode_s2;
        logic [1:0] found_s1;
        logic [1:0] found_s2;
        logic [lane_cfg_pkg::DIV_W-1:0] div;
        logic tick;
        logic [1:0][7:0] det;
        logic [1:0][7:0] boost;
        logic [7:0] rsv10;
        logic [7:0] rsv11;
        logic [7:0] rsv12;
        logic [7:0] swing;
        logic [7:0] rdata;
        logic [3:0] eff_prev;
        logic [1:0] restart;
        logic proto;
    } bank_st_t;

    localparam logic [lane_cfg_pkg::DIV_W-1:0] DIV_LAST =
        lane_cfg_pkg::DIV_W'(PROBE_CYC - 1);

    bank_st_t s;
    bank_st_t n;
    logic [3:0] eff_mode;
    logic write_ok;

    function automatic logic is_auto(input logic [1:0] code);
        is_auto = (code == lane_cfg_pkg::SENSE_AUTO_LIM) ||
                  (code == lane_cfg_pkg::SENSE_AUTO_ANY);
    endfunction : is_auto

    // lane writes gated by enable or checksum
    assign write_ok = reg_enable_i || checksum_ok_i;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            assign eff_mode[2*g +: 2] = detect_override_i ?
                s.det[g][lane_cfg_pkg::SENSE_LSB +: 2] :
                s.sense_s2[2*g +: 2];

            far_end_sense u_sense (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .tick_i(s.tick),
                .restart_i(s.restart[g]),
                .mode_i(eff_mode[2*g +: 2]),
                .found_i(s.found_s2[g]),
                .probe_o(probe_o[g]),
                .term_o(term_50ohm_o[g]),
                .detected_o(detected_o[g])
            );
        end
    endgenerate

    always_comb begin
        n = s;
        n.sense_s1 = ext_sense_mode_i;
        n.sense_s2 = s.sense_s1;
        n.mode_s1 = mode_pin_i;
        n.mode_s2 = s.mode_s1;
        n.found_s1 = receiver_found_i;
        n.found_s2 = s.found_s1;
        n.tick = 1'b0;
        if (s.div == DIV_LAST) begin
            n.div = '0;
            n.tick = 1'b1;
        end else begin
            n.div = s.div + 1'b1;
        end
        // mode change also restarts the sequence
        n.eff_prev = eff_mode;
        n.restart[0] = (eff_mode[1:0] != s.eff_prev[1:0]);
        n.restart[1] = (eff_mode[3:2] != s.eff_prev[3:2]);
        if (reg_wr_i && write_ok) begin
            unique case (reg_addr_i)
                lane_cfg_pkg::ADDR_DET0: begin
                    n.det[0] = reg_wdata_i;
                    if (is_auto(reg_wdata_i[lane_cfg_pkg::SENSE_LSB +: 2]) &&
                        detect_override_i) begin
                        n.restart[0] = 1'b1;
                    end
                end
                lane_cfg_pkg::ADDR_DET1: begin
                    n.det[1] = reg_wdata_i;
                    if (is_auto(reg_wdata_i[lane_cfg_pkg::SENSE_LSB +: 2]) &&
                        detect_override_i) begin
                        n.restart[1] = 1'b1;
                    end
                end
                lane_cfg_pkg::ADDR_BOOST0: n.boost[0] = reg_wdata_i;
                lane_cfg_pkg::ADDR_BOOST1: n.boost[1] = reg_wdata_i;
                lane_cfg_pkg::ADDR_RSV10: n.rsv10 = reg_wdata_i;
                lane_cfg_pkg::ADDR_RSV11: n.rsv11 = reg_wdata_i;
                lane_cfg_pkg::ADDR_RSV12: n.rsv12 = reg_wdata_i;
                lane_cfg_pkg::ADDR_SWING1: n.swing = reg_wdata_i;
                default: n.swing = s.swing;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                lane_cfg_pkg::ADDR_DET0: n.rdata = s.det[0];
                lane_cfg_pkg::ADDR_DET1: n.rdata = s.det[1];
                lane_cfg_pkg::ADDR_BOOST0: n.rdata = s.boost[0];
                lane_cfg_pkg::ADDR_BOOST1: n.rdata = s.boost[1];
                lane_cfg_pkg::ADDR_RSV10: n.rdata = s.rsv10;
                lane_cfg_pkg::ADDR_RSV11: n.rdata = s.rsv11;
                lane_cfg_pkg::ADDR_RSV12: n.rdata = s.rsv12;
                lane_cfg_pkg::ADDR_SWING1: n.rdata = s.swing;
                default: n.rdata = 8'h00;
            endcase
        end
        n.proto = mode_override_i ? s.swing[lane_cfg_pkg::PROTO_BIT] :
            s.mode_s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.det[0] <= lane_cfg_pkg::RST_DET;
            s.det[1] <= lane_cfg_pkg::RST_DET;
            s.boost[0] <= lane_cfg_pkg::RST_BOOST;
            s.boost[1] <= lane_cfg_pkg::RST_BOOST;
            s.rsv10 <= lane_cfg_pkg::RST_RSV10;
            s.rsv11 <= lane_cfg_pkg::RST_RSV11;
            s.rsv12 <= lane_cfg_pkg::RST_RSV12;
            s.swing <= lane_cfg_pkg::RST_SWING;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata_o = s.rdata;
    assign input_boost_level_o = {s.boost[1], s.boost[0]};
    // swing code drives the output level
    assign output_swing_o = s.swing[lane_cfg_pkg::SWING_LSB +: 3];
    // protocol mode from the chosen source
    assign protocol_mode_o = s.proto;
    assign short_protect_o = s.swing[lane_cfg_pkg::SHORT_BIT];

    boost_reset_a: assert property (
        @(posedge clk_i) $fell(rst_i) |->
        input_boost_level_o ==
        {lane_cfg_pkg::RST_BOOST, lane_cfg_pkg::RST_BOOST} &&
        output_swing_o == lane_cfg_pkg::RST_SWING[lane_cfg_pkg::SWING_LSB +: 3])
        else $error("bad reset values");
    gated_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_wr_i && !write_ok) |=> $stable(s.swing) && $stable(s.boost))
        else $error("write taken without enable");
    proto_source_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (mode_override_i && $stable(s.swing)) |=>
        protocol_mode_o == $past(s.swing[lane_cfg_pkg::PROTO_BIT]))
        else $error("protocol mode wrong source");
    short_bit_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_wr_i && write_ok && reg_addr_i == lane_cfg_pkg::ADDR_SWING1) |=>
        short_protect_o == $past(reg_wdata_i[lane_cfg_pkg::SHORT_BIT]))
        else $error("protection bit not written");
    auto_restart_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_wr_i && write_ok && detect_override_i &&
        reg_addr_i == lane_cfg_pkg::ADDR_DET0 &&
        reg_wdata_i[lane_cfg_pkg::SENSE_LSB +: 2] ==
        lane_cfg_pkg::SENSE_AUTO_ANY) |=> s.restart[0])
        else $error("auto rewrite did not restart");
endmodule : lane_config_register_bank

/* sim/cfg_host.sv */
// host side model that writes and reads the lane configuration registers
// assumes the bank samples its strobes on the rising edge of clk_i
`timescale 1ns/100ps
module cfg_host (
    input wire logic clk_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == lane_cfg_pkg::ADDR_SWING1) begin
            v[5:3] = 3'h5;
        end
        if (a == lane_cfg_pkg::ADDR_DET0 ||
            a == lane_cfg_pkg::ADDR_DET1) begin
            v = v & 8'h0c;
        end
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // released data is scrambled so a stale value cannot pass
        wdata_o <= ~v;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
    endtask : rd
endmodule : cfg_host

/* sim/lane_config_register_bank_test.sv */
// self-checking bench for the lane configuration register bank
// assumes cfg_host drives the register port; probe period shortened to 20
`timescale 1ns/100ps
module lane_config_register_bank_test;
    localparam int unsigned PCYC = 20;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] rst;
        logic [7:0] wval;
        logic [7:0] exp;
    } row_t;
    logic clk_i, rst_i, reg_wr, reg_rd, reg_enable, checksum_ok;
    logic det_ovr, mode_ovr, mode_pin, proto, short_p;
    logic [7:0] reg_addr, reg_wdata, rdata;
    logic [3:0] ext_sense;
    logic [1:0] found, probe, term, det;
    logic [15:0] boost;
    logic [2:0] swing;
    int mismatches = 0;
    int n_tests = 0;
    int probes0 = 0;
    int probes1 = 0;
    // unmapped 0x13 last: writes dropped, reads give zero
    row_t rows [9] = '{
        '{8'h0e, 8'h00, 8'h08, 8'h08}, '{8'h0f, 8'h2f, 8'ha5, 8'ha5},
        '{8'h10, 8'had, 8'had, 8'had}, '{8'h11, 8'h02, 8'h02, 8'h02},
        '{8'h12, 8'h00, 8'h00, 8'h00}, '{8'h15, 8'h00, 8'h0c, 8'h0c},
        '{8'h16, 8'h2f, 8'h5a, 8'h5a}, '{8'h17, 8'had, 8'h6a, 8'h6a},
        '{8'h13, 8'h00, 8'hff, 8'h00}};

    cfg_host u_host (.clk_i(clk_i), .addr_o(reg_addr), .wdata_o(reg_wdata),
        .wr_o(reg_wr), .rd_o(reg_rd));

    lane_config_register_bank #(.PROBE_CYC(PCYC)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(rdata), .reg_enable_i(reg_enable),
        .checksum_ok_i(checksum_ok), .detect_override_i(det_ovr),
        .mode_override_i(mode_ovr), .ext_sense_mode_i(ext_sense),
        .mode_pin_i(mode_pin), .receiver_found_i(found), .probe_o(probe),
        .term_50ohm_o(term), .detected_o(det), .input_boost_level_o(boost),
        .output_swing_o(swing), .protocol_mode_o(proto),
        .short_protect_o(short_p));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (probe[0] === 1'b1) probes0++;
        if (probe[1] === 1'b1) probes1++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a);
        #1;
        chk({8'h00, rdata}, {8'h00, e});
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic end_of_test();
        $display("mismatches %0d, checks %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        rst_i <= 1'b1;
        {reg_enable, checksum_ok, det_ovr, mode_pin, found} <= 6'h00;
        mode_ovr <= 1'b1;
        ext_sense <= 4'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        reg_enable <= 1'b1;
        foreach (rows[i]) begin
            rd_chk(rows[i].addr, rows[i].rst);
            u_host.wr(rows[i].addr, rows[i].wval);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        chk(boost, 16'h5aa5);
        chk({11'h0, short_p, proto, swing}, 16'h000a);
        @(posedge clk_i) reg_enable <= 1'b0;
        u_host.wr(8'h0f, 8'h11);
        rd_chk(8'h0f, 8'ha5);
        @(posedge clk_i) checksum_ok <= 1'b1;
        u_host.wr(8'h0f, 8'h11);
        rd_chk(8'h0f, 8'h11);
        @(posedge clk_i) {reg_enable, checksum_ok} <= 2'b10;
        u_host.wr(8'h17, 8'haa);
        settle(1);
        chk({11'h0, short_p, proto, swing}, 16'h0012);
        @(posedge clk_i) {mode_ovr, mode_pin} <= 2'b01;
        settle(6);
        chk({15'h0, proto}, 16'h0001);
        @(posedge clk_i) det_ovr <= 1'b1;
        u_host.wr(8'h0e, 8'h00);
        settle(6);
        chk({15'h0, term[0]}, 16'h0000);
        u_host.wr(8'h0e, 8'h0c);
        settle(6);
        chk({15'h0, term[0]}, 16'h0001);
        probes0 = 0;
        probes1 = 0;
        u_host.wr(8'h0e, 8'h04);
        u_host.wr(8'h15, 8'h08);
        settle(55 * PCYC);
        chk(16'(probes0), 16'd50);
        chk({15'h0, probes1 > 50}, 16'h0001);
        chk({12'h0, det, term}, 16'h0000);
        @(posedge clk_i) found <= 2'b10;
        settle(6);
        chk({12'h0, det, term}, 16'h000a);
        u_host.wr(8'h0e, 8'h04);
        probes0 = 0;
        settle(5 * PCYC);
        chk({15'h0, probes0 >= 4}, 16'h0001);
        @(posedge clk_i) {det_ovr, ext_sense} <= 5'h03;
        settle(8);
        chk({14'h0, term}, 16'h0001);
        // mid-run reset must bring every register back to its default
        @(posedge clk_i) rst_i <= 1'b1;
        settle(2);
        @(posedge clk_i) rst_i <= 1'b0;
        settle(1);
        chk(boost, 16'h2f2f);
        chk({12'h0, short_p, swing}, 16'h000d);
        chk({4'h0, rdata, det, term}, 16'h0000);
        rd_chk(8'h17, 8'had);
        settle(8);
        chk({14'h0, term}, 16'h0001);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        end_of_test();
    end
endmodule : lane_config_register_bank_test
